// ==== hdl/tws_regs.vh ====
/*
  Constants for the two-wire slave block: register offsets, field
  positions, status codes and bit counts.
  Assumes it is included once per design file by its bare name.
*/
// Notes on behaviour
// - General-call data acked reports 0x90
// - General-call data nacked reports 0x98, then idle
// - STOP or restart while addressed as receiver reports 0xA0
// - Idle recognition follows acknowledge and call enable
// - Start bit with idle response requests START
// - Upper seven address bits; bit0 enables call
// - Direction bit picks transmit or receive
// - Acked address sets flag with status
// - Lost arbitration read address reports 0xB0
// - Cleared acknowledge sends last byte, 0xC0/0xC8
// - After last byte release bus, ignore clocks
// - Acknowledge clear isolates, setting resumes
// - Asleep match wakes part, holds clock low
// - Own write data nacked reports 0x88
// - Own read address acked reports 0xA8
// - Transmitted byte acked reports 0xB8
// - Status reads 0xF8 while flag clear
`ifndef TWS_REGS_VH
`define TWS_REGS_VH

// Byte offsets on the APB
`define TWS_OFS_ADDR   8'h00
`define TWS_OFS_CTRL   8'h04
`define TWS_OFS_STAT   8'h08
`define TWS_OFS_DATA   8'h0C

// Control field positions
`define TWS_C_FLAG     7
`define TWS_C_EA       6
`define TWS_C_STA      5
`define TWS_C_STO      4
`define TWS_C_WC       3
`define TWS_C_EN       2
`define TWS_C_IE       0

// Status codes
`define TWS_ST_SRW     8'h60
`define TWS_ST_SRW_AL  8'h68
`define TWS_ST_GC      8'h70
`define TWS_ST_GC_AL   8'h78
`define TWS_ST_RD_ACK  8'h80
`define TWS_ST_RD_NAK  8'h88
`define TWS_ST_GD_ACK  8'h90
`define TWS_ST_GD_NAK  8'h98
`define TWS_ST_STOP    8'hA0
`define TWS_ST_SLR     8'hA8
`define TWS_ST_SLR_AL  8'hB0
`define TWS_ST_TD_ACK  8'hB8
`define TWS_ST_TD_NAK  8'hC0
`define TWS_ST_LAST_AK 8'hC8
`define TWS_ST_NONE    8'hF8

// Bit counts, general-call address and reset values
`define TWS_BITS       4'h8
`define TWS_LAST_BIT   4'h7
`define TWS_GC_ADDR    7'h00
`define TWS_RST_BYTE   8'h00
`define TWS_RST_DATA   8'hFF

`endif

// ==== hdl/tws_sync.v ====
/*
  Two-flop synchroniser for one level from outside the mclk domain.
  Assumes the input is asynchronous; only stage two may be read.
*/
`timescale 1ns/1ps
module tws_sync (
    input  wire mclk,
    input  wire reset_n,
    input  wire din,
    output wire dout
);
    reg meta_reg;   // First stage, read only by second
    reg sync_reg;   // Second stage, safe to use

    // Idle bus level is high, so reset to one
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            meta_reg <= 1'b1;
            sync_reg <= 1'b1;
        end else begin
            meta_reg <= din;
            sync_reg <= meta_reg;
        end
    end

    assign dout = sync_reg;
endmodule

// ==== hdl/tws_shift.v ====
/*
  Byte shifter with bit counter, shared by address, receive and
  transmit phases. Assumes load and shift never come in one cycle.
*/
`timescale 1ns/1ps
`include "tws_regs.vh"
module tws_shift (
    input  wire       mclk,
    input  wire       reset_n,
    input  wire       load,
    input  wire [7:0] load_val,
    input  wire       shift_en,
    input  wire       shift_bit,
    output wire [7:0] data,
    output wire [3:0] count
);
    reg [7:0] data_reg;   // Shifted byte, msb first
    reg [3:0] cnt_reg;    // Shifts since load

    // Load clears the count, each shift adds one
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            data_reg <= `TWS_RST_BYTE;
            cnt_reg  <= 4'h0;
        end else if (load) begin
            data_reg <= load_val;
            cnt_reg  <= 4'h0;
        end else if (shift_en) begin
            data_reg <= {data_reg[6:0], shift_bit};
            cnt_reg  <= cnt_reg + 4'h1;
        end
    end

    assign data  = data_reg;
    assign count = cnt_reg;
endmodule

// ==== hdl/tws_slave_top.v ====
/*
  Two-wire slave receiver and transmitter with APB register access.
  Assumes a 10 MHz mclk, bus pins with external pull-ups, and a
  master engine elsewhere that reports lost arbitration and acts on
  the start request output.
*/
// The implementer's own choices: register access over APB and the placing of the registers.
`timescale 1ns/1ps
`include "tws_regs.vh"
module tws_slave_top (
    input  wire        mclk,
    input  wire        reset_n,
    input  wire [7:0]  paddr,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [31:0] pwdata,
    output wire [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    input  wire        scl_in,
    output wire        scl_out,
    output wire        scl_oe_n,
    input  wire        sda_in,
    output wire        sda_out,
    output wire        sda_oe_n,
    input  wire        sleep_active,
    input  wire        arb_lost,
    output wire        wake_req,
    output wire        bus_start_req
);
    // One-hot engine states
    localparam [7:0] S_IDLE = 8'h01;  // Not addressed, lines free
    localparam [7:0] S_ADDR = 8'h02;  // Shifting address byte
    localparam [7:0] S_AACK = 8'h04;  // Driving address ack
    localparam [7:0] S_RXB  = 8'h08;  // Receiving data byte
    localparam [7:0] S_RACK = 8'h10;  // Ack slot after data
    localparam [7:0] S_TXB  = 8'h20;  // Sending data byte
    localparam [7:0] S_TACK = 8'h40;  // Master ack slot
    localparam [7:0] S_HOLD = 8'h80;  // Flag set, SCL held low

    reg  [7:0]  state_reg;     // Engine state
    reg  [7:0]  state_next;    // Next engine state
    reg  [7:0]  target_reg;    // State taken on release
    reg  [7:0]  target_next;
    reg  [7:0]  osa_reg;       // Own slave address register
    reg  [7:0]  code_reg;      // Latched status code
    reg  [7:0]  code_next;
    reg  [1:0]  presc_reg;     // Prescaler bits of status
    reg  [7:0]  data_reg;      // Serial data register
    reg         flag_reg;      // Job done flag
    reg         ea_reg;        // Acknowledge enable
    reg         sta_reg;       // Start request
    reg         sto_reg;       // Stop request
    reg         wc_reg;        // Write collision flag
    reg         en_reg;        // Interface enable
    reg         ie_reg;        // Interrupt enable, stored only
    reg         gc_reg;        // Addressed by general call
    reg         gc_next;
    reg         ack_reg;       // Ack we give in receive slot
    reg         ack_next;
    reg         last_reg;      // Byte sent is the last one
    reg         last_next;
    reg         mack_reg;      // Master answered ack
    reg         mack_next;
    reg         pend_reg;      // START wanted when bus frees
    reg         busy_reg;      // Bus between START and STOP
    reg         wake_reg;      // Wake pulse
    reg         set_ev;        // Engine sets the flag
    reg         to_idle;       // Release into idle state
    reg         sh_load;
    reg  [7:0]  sh_val;
    reg         sh_en;
    reg  [31:0] prdata_reg;    // Read data, latched at setup
    reg         scl_d;         // Delayed synced SCL
    reg         sda_d;         // Delayed synced SDA

    wire        scl_s;
    wire        sda_s;
    wire [7:0]  sh_data;
    wire [3:0]  sh_cnt;

    // Pin synchronisers
    tws_sync u_sync_scl (
        .mclk    (mclk),
        .reset_n (reset_n),
        .din     (scl_in),
        .dout    (scl_s)
    );
    tws_sync u_sync_sda (
        .mclk    (mclk),
        .reset_n (reset_n),
        .din     (sda_in),
        .dout    (sda_s)
    );

    // Shared byte shifter
    tws_shift u_shift (
        .mclk      (mclk),
        .reset_n   (reset_n),
        .load      (sh_load),
        .load_val  (sh_val),
        .shift_en  (sh_en),
        .shift_bit (sda_s),
        .data      (sh_data),
        .count     (sh_cnt)
    );

    // Pin edges and bus conditions
    wire scl_rise = scl_s & ~scl_d;
    wire scl_fall = ~scl_s & scl_d;
    wire start_ev = scl_s & scl_d & sda_d & ~sda_s;
    wire stop_ev  = scl_s & scl_d & ~sda_d & sda_s;

    // APB decode; zero-wait slave
    wire acc     = psel & penable;
    wire wr_acc  = acc & pwrite;
    wire ctrl_wr = wr_acc & (paddr == `TWS_OFS_CTRL);
    wire rel     = ctrl_wr & pwdata[`TWS_C_FLAG] & flag_reg;

    // Acknowledge enable as it stands after a write this cycle
    wire ea_now  = ctrl_wr ? pwdata[`TWS_C_EA] : ea_reg;

    // Status byte as software sees it; idle code while flag clear
    wire [7:0] stat_code = flag_reg ? code_reg : `TWS_ST_NONE;

    // Offset decode, used for error answer only; read mux decodes by case
    function mapped;
        input [7:0] a;
        begin
            mapped = (a == `TWS_OFS_ADDR) | (a == `TWS_OFS_CTRL) |
                     (a == `TWS_OFS_STAT) | (a == `TWS_OFS_DATA);
        end
    endfunction

    // Address byte hits own or enabled general call
    wire own_hit = sh_data[7:1] == osa_reg[7:1];
    wire gc_hit  = (sh_data[7:1] == `TWS_GC_ADDR) & osa_reg[0]
                   & ~sh_data[0];
    wire match   = en_reg & ea_reg & (own_hit | gc_hit);

    // Engine next-state logic
    always @* begin
        state_next  = state_reg;
        target_next = target_reg;
        code_next   = code_reg;
        gc_next     = gc_reg;
        ack_next    = ack_reg;
        last_next   = last_reg;
        mack_next   = mack_reg;
        set_ev      = 1'b0;
        to_idle     = 1'b0;
        sh_load     = 1'b0;
        sh_val      = `TWS_RST_BYTE;
        sh_en       = 1'b0;
        if (!en_reg) begin
            // Disabled: lines free, engine back to idle
            state_next = S_IDLE;
        end else if ((start_ev | stop_ev) &
                     (state_reg == S_RXB || state_reg == S_RACK)) begin
            // Condition seen while addressed as receiver
            code_next   = `TWS_ST_STOP;
            set_ev      = 1'b1;
            target_next = S_IDLE;
            state_next  = S_HOLD;
        end else if (start_ev && state_reg != S_HOLD) begin
            // START outside hold and receive restarts address shifting
            sh_load    = 1'b1;
            state_next = S_ADDR;
        end else if (stop_ev && state_reg != S_HOLD) begin
            state_next = S_IDLE;
        end else begin
            case (state_reg)
                S_IDLE: begin
                    // Ignore clocks, drive nothing
                    state_next = S_IDLE;
                end
                S_ADDR: begin
                    if (scl_rise) begin
                        sh_en = 1'b1;
                    end else if (scl_fall && sh_cnt == `TWS_BITS) begin
                        if (match) begin
                            gc_next    = ~own_hit;
                            state_next = S_AACK;
                        end else begin
                            state_next = S_IDLE;
                        end
                    end
                end
                S_AACK: begin
                    if (scl_fall) begin
                        set_ev     = 1'b1;
                        state_next = S_HOLD;
                        if (sh_data[0]) begin
                            // Read: slave transmits
                            target_next = S_TXB;
                            code_next = arb_lost ? `TWS_ST_SLR_AL
                                                 : `TWS_ST_SLR;
                        end else begin
                            target_next = S_RXB;
                            if (gc_reg)
                                code_next = arb_lost ? `TWS_ST_GC_AL
                                                     : `TWS_ST_GC;
                            else
                                code_next = arb_lost ? `TWS_ST_SRW_AL
                                                     : `TWS_ST_SRW;
                        end
                    end
                end
                S_RXB: begin
                    if (scl_rise) begin
                        sh_en = 1'b1;
                    end else if (scl_fall && sh_cnt == `TWS_BITS) begin
                        // Answer follows acknowledge enable now
                        ack_next   = ea_reg;
                        state_next = S_RACK;
                    end
                end
                S_RACK: begin
                    if (scl_fall) begin
                        set_ev      = 1'b1;
                        state_next  = S_HOLD;
                        target_next = ack_reg ? S_RXB : S_IDLE;
                        if (gc_reg)
                            code_next = ack_reg ? `TWS_ST_GD_ACK
                                                : `TWS_ST_GD_NAK;
                        else
                            code_next = ack_reg ? `TWS_ST_RD_ACK
                                                : `TWS_ST_RD_NAK;
                    end
                end
                S_TXB: begin
                    if (scl_fall) begin
                        sh_en = 1'b1;
                        if (sh_cnt == `TWS_LAST_BIT)
                            state_next = S_TACK;
                    end
                end
                S_TACK: begin
                    if (scl_rise) begin
                        mack_next = ~sda_s;
                    end else if (scl_fall) begin
                        set_ev     = 1'b1;
                        state_next = S_HOLD;
                        if (mack_reg && !last_reg) begin
                            code_next   = `TWS_ST_TD_ACK;
                            target_next = S_TXB;
                        end else begin
                            code_next = mack_reg ? `TWS_ST_LAST_AK
                                                 : `TWS_ST_TD_NAK;
                            target_next = S_IDLE;
                        end
                    end
                end
                S_HOLD: begin
                    // Wait for software to release the flag
                    if (rel) begin
                        state_next = target_reg;
                        to_idle    = (target_reg == S_IDLE);
                        if (target_reg == S_TXB) begin
                            sh_load   = 1'b1;
                            sh_val    = data_reg;
                            last_next = ~ea_now;
                        end else if (target_reg == S_RXB) begin
                            sh_load = 1'b1;
                        end
                    end
                end
                default: begin
                    state_next = S_IDLE;
                end
            endcase
        end
    end

    // Engine registers and pin history
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            state_reg  <= S_IDLE;
            target_reg <= S_IDLE;
            code_reg   <= `TWS_ST_NONE;
            gc_reg     <= 1'b0;
            ack_reg    <= 1'b0;
            last_reg   <= 1'b0;
            mack_reg   <= 1'b0;
            scl_d      <= 1'b1;
            sda_d      <= 1'b1;
        end else begin
            state_reg  <= state_next;
            target_reg <= target_next;
            code_reg   <= code_next;
            gc_reg     <= gc_next;
            ack_reg    <= ack_next;
            last_reg   <= last_next;
            mack_reg   <= mack_next;
            scl_d      <= scl_s;
            sda_d      <= sda_s;
        end
    end

    // Flag, control bits and software registers
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            flag_reg  <= 1'b0;
            ea_reg    <= 1'b0;
            sta_reg   <= 1'b0;
            sto_reg   <= 1'b0;
            wc_reg    <= 1'b0;
            en_reg    <= 1'b0;
            ie_reg    <= 1'b0;
            osa_reg   <= `TWS_RST_BYTE;
            presc_reg <= 2'h0;
            data_reg  <= `TWS_RST_DATA;
            pend_reg  <= 1'b0;
            busy_reg  <= 1'b0;
            wake_reg  <= 1'b0;
        end else begin
            // Set beats a release landing in the same cycle
            if (set_ev)
                flag_reg <= 1'b1;
            else if (rel)
                flag_reg <= 1'b0;
            if (ctrl_wr) begin
                ea_reg <= pwdata[`TWS_C_EA];
                sta_reg <= pwdata[`TWS_C_STA];
                sto_reg <= pwdata[`TWS_C_STO];
                en_reg <= pwdata[`TWS_C_EN];
                ie_reg <= pwdata[`TWS_C_IE];
            end
            // Stop bit has no slave use; a release clears it
            if (rel)
                sto_reg <= 1'b0;
            // Start with an idle response waits for free bus
            if (to_idle)
                pend_reg <= ctrl_wr ? pwdata[`TWS_C_STA] : sta_reg;
            else if (ctrl_wr && !pwdata[`TWS_C_STA])
                pend_reg <= 1'b0;
            if (wr_acc && paddr == `TWS_OFS_ADDR)
                osa_reg <= pwdata[7:0];
            if (wr_acc && paddr == `TWS_OFS_STAT)
                presc_reg <= pwdata[1:0];
            // Data write only legal while flag is set
            if (wr_acc && paddr == `TWS_OFS_DATA) begin
                if (flag_reg) begin
                    data_reg <= pwdata[7:0];
                    wc_reg   <= 1'b0;
                end else begin
                    wc_reg   <= 1'b1;
                end
            end else if (ctrl_wr && !pwdata[`TWS_C_WC]) begin
                wc_reg <= 1'b0;
            end
            // Received byte lands at the ack slot
            if (state_reg == S_RACK && scl_fall)
                data_reg <= sh_data;
            if (start_ev)
                busy_reg <= 1'b1;
            else if (stop_ev)
                busy_reg <= 1'b0;
            // Address hit while asleep asks for wake-up
            wake_reg <= sleep_active & (state_reg == S_AACK) & scl_fall;
        end
    end

    // Read data latched in the setup cycle
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            prdata_reg <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            case (paddr)
                `TWS_OFS_ADDR: prdata_reg <= {24'h00_0000, osa_reg};
                `TWS_OFS_CTRL: prdata_reg <= {24'h00_0000, flag_reg,
                    ea_reg, sta_reg, sto_reg, wc_reg, en_reg, 1'b0,
                    ie_reg};
                // Code bits above the prescaler bits
                `TWS_OFS_STAT: prdata_reg <= {24'h00_0000,
                    stat_code[7:3], 1'b0, presc_reg};
                `TWS_OFS_DATA: prdata_reg <= {24'h00_0000, data_reg};
                default:       prdata_reg <= 32'h0000_0000;
            endcase
        end
    end

    assign prdata  = prdata_reg;
    assign pready  = 1'b1;
    assign pslverr = acc & ~mapped(paddr);

    // Open-drain pins: output low, enable active low
    assign scl_out  = 1'b0;
    assign sda_out  = 1'b0;
    assign scl_oe_n = ~(state_reg == S_HOLD);
    assign sda_oe_n = ~((state_reg == S_AACK) |
                        (state_reg == S_RACK & ack_reg) |
                        (state_reg == S_TXB & ~sh_data[7]));
    assign wake_req      = wake_reg;
    assign bus_start_req = pend_reg & ~busy_reg;
endmodule

// ==== testbench/tws_slave_asserts.sv ====
/*
  Checker of pin and register-read relations of the slave top.
  Assumes a bind onto tws_slave_top; sees its ports only.
*/
`timescale 1ns/1ps
module tws_slave_asserts (
    input wire        mclk,
    input wire        reset_n,
    input wire [7:0]  paddr,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire        pslverr,
    input wire        scl_in,
    input wire        scl_out,
    input wire        scl_oe_n,
    input wire        sda_out,
    input wire        sda_oe_n,
    input wire        wake_req,
    input wire        bus_start_req
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!reset_n);
    // Flag release write
    wire rel = psel && penable && pwrite && paddr == 8'h04 && pwdata[7];

    hold_low_a: assert property ($fell(scl_oe_n) |-> ##1 !scl_in)
        else $error("clock not held");
    hold_keep_a:
        assert property (!scl_oe_n && !rel && !$past(rel) |=> !scl_oe_n)
        else $error("hold dropped early");
    start_free_a:
        assert property ($rose(bus_start_req) |-> scl_in && sda_out == 1'b0)
        else $error("start on busy bus");
    wake_pulse_a: assert property (wake_req |=> !wake_req)
        else $error("long wake pulse");
    wake_hold_a: assert property (wake_req |-> ##[0:3] !scl_oe_n)
        else $error("wake without hold");
    status_idle_a:
        assert property (psel && !penable && !pwrite && paddr == 8'h08
            && scl_oe_n ##1 scl_oe_n |-> prdata[7:3] == 5'h1F)
        else $error("status not idle");
    sda_quiet_a:
        assert property ($changed(sda_oe_n) |-> !scl_in || !$past(scl_in))
        else $error("data moved, clock high");
    open_drain_a: assert property (!scl_out && !sda_out)
        else $error("line driven high");
    cover property (wake_req);
    cover property ($rose(bus_start_req));
    cover property (pslverr);
endmodule

bind tws_slave_top tws_slave_asserts i_chk (.mclk(mclk), .reset_n(reset_n),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .prdata(prdata), .pslverr(pslverr),
    .scl_in(scl_in), .scl_out(scl_out), .scl_oe_n(scl_oe_n),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n),
    .wake_req(wake_req), .bus_start_req(bus_start_req));

// ==== testbench/tws_master_model.sv ====
/*
  Behavioural two-wire bus master, 800 ns clock, honours clock holds.
  Assumes pull-ups: the bench wired-ANDs both lines.
*/
`timescale 1ns/1ps
module tws_master_model (
    output logic scl_m,
    output logic sda_m,
    input  wire  scl,
    input  wire  sda
);
    logic r; // Sampled line value
    initial begin
        scl_m = 1'b1;
        sda_m = 1'b1;
    end
    // One bit; waits out clock holds
    task automatic bit_io(input logic b, output logic q);
        sda_m = b;
        #200;
        scl_m = 1'b1;
        wait (scl === 1'b1);
        #200;
        q = sda;
        #200;
        scl_m = 1'b0;
        #200;
    endtask
    // START or restart, no stray clock
    task automatic start();
        sda_m = 1'b1;
        #200;
        scl_m = 1'b1;
        wait (scl === 1'b1);
        #200;
        sda_m = 1'b0;
        #200;
        scl_m = 1'b0;
        #200;
    endtask
    task automatic stop();
        sda_m = 1'b0;
        #200;
        scl_m = 1'b1;
        wait (scl === 1'b1);
        #200;
        sda_m = 1'b1;
        #400;
    endtask
    // Byte out msb first, returns ack
    task automatic wbyte(input logic [7:0] d, output logic ack);
        for (int i = 7; i >= 0; i--)
            bit_io(d[i], r);
        bit_io(1'b1, r);
        ack = ~r;
    endtask
    // Byte in, then ack or nack
    task automatic rbyte(input logic ack, output logic [7:0] d);
        for (int i = 7; i >= 0; i--)
            bit_io(1'b1, d[i]);
        bit_io(~ack, r);
    endtask
endmodule

// ==== testbench/two_wire_slave_rx_tx_bench.sv ====
/*
  Bench for the two-wire slave: APB tasks and a bus master.
  Assumes pulled-up lines, modelled as wired-AND.
*/
`timescale 1ns/1ps
module two_wire_slave_rx_tx_bench;
    logic        mclk = 1'b0;
    logic        reset_n = 1'b0;
    logic [7:0]  paddr;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite;
    logic [31:0] pwdata;
    logic        sleep_active = 1'b0;
    logic        arb_lost = 1'b0;
    wire  [31:0] prdata;
    wire         pready, pslverr, scl_out, scl_oe_n, sda_out, sda_oe_n;
    wire         wake_req, bus_start_req, scl_m, sda_m;
    wire         scl = scl_m & scl_oe_n; // Pulled-up line
    wire         sda = sda_m & sda_oe_n;
    int          n_mismatch = 0;
    int          n_tests = 0;
    int          n_wake = 0;
    logic [31:0] rd;   // Last read word
    logic        perr; // Last error flag
    logic        ack;  // Last ack slot
    logic [7:0]  rx;   // Last byte read

    always #50 mclk = ~mclk;
    // Count wake pulses
    always @(posedge mclk) if (wake_req) n_wake++;

    tws_slave_top i_dut (.mclk(mclk), .reset_n(reset_n), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .scl_in(scl),
        .scl_out(scl_out), .scl_oe_n(scl_oe_n), .sda_in(sda),
        .sda_out(sda_out), .sda_oe_n(sda_oe_n), .arb_lost(arb_lost),
        .sleep_active(sleep_active), .wake_req(wake_req),
        .bus_start_req(bus_start_req));
    tws_master_model i_mst (.scl_m(scl_m), .sda_m(sda_m), .scl(scl),
        .sda(sda));

    task automatic mm(input string s);
        n_mismatch++;
        $display("mismatch at %0t: %s", $time, s);
    endtask
    // APB transfer, held to pready
    task automatic apb(input logic [7:0] a, input logic w,
                       input logic [31:0] d);
        @(posedge mclk);
        psel    <= 1'b1;
        paddr   <= a;
        pwrite  <= w;
        pwdata  <= d;
        @(posedge mclk);
        penable <= 1'b1;
        @(posedge mclk);
        while (pready !== 1'b1)
            @(posedge mclk);
        rd = prdata;
        perr = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, d);
        apb(a, 1'b1, {24'h0, d});
    endtask
    task automatic chk(input logic [7:0] a, e, m);
        apb(a, 1'b0, 32'h0);
        n_tests++;
        if ((rd[7:0] & m) !== e)
            mm($sformatf("reg %h read %h", a, rd[7:0]));
    endtask
    // Masked status once the clock is held
    task automatic st(input logic [7:0] e);
        for (int i = 0; i < 80 && scl_oe_n !== 1'b0; i++)
            @(posedge mclk);
        chk(8'h08, e, 8'hF8);
    endtask
    task automatic wb(input logic [7:0] d, input logic e);
        i_mst.wbyte(d, ack);
        n_tests++;
        if (ack !== e)
            mm("ack slot");
    endtask
    task automatic rb(input logic a, input logic [7:0] e);
        i_mst.rbyte(a, rx);
        n_tests++;
        if (rx !== e)
            mm("read byte");
    endtask
    // Slave transmit, second byte marked last
    task automatic txs(input logic al, mack, input logic [7:0] es);
        @(posedge mclk);
        arb_lost <= al;
        i_mst.start();
        wb(8'h55, 1'b1);
        st(al ? 8'hB0 : 8'hA8);
        arb_lost <= 1'b0;
        wr(8'h0C, 8'h96);
        wr(8'h04, 8'hC4);
        rb(1'b1, 8'h96);
        st(8'hB8);
        wr(8'h0C, 8'h5A);
        wr(8'h04, 8'h84);
        rb(mack, 8'h5A);
        st(es);
        wr(8'h04, 8'hC4);
        rb(1'b1, 8'hFF);
        i_mst.stop();
    endtask
    task automatic results();
        if (n_mismatch == 0 && n_tests > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    initial begin
        repeat (4) @(posedge mclk);
        reset_n <= 1'b1;
        chk(8'h0C, 8'hFF, 8'hFF);
        chk(8'h08, 8'hF8, 8'hFF);
        chk(8'h00, 8'h00, 8'hFF);
        apb(8'h10, 1'b0, 32'h0);
        n_tests++;
        if (perr !== 1'b1 || rd !== 32'h0)
            mm("unmapped offset");
        wr(8'h00, 8'h55);
        wr(8'h0C, 8'h12);
        chk(8'h04, 8'h08, 8'h08);
        wr(8'h04, 8'h44);
        i_mst.start();
        wb(8'h54, 1'b1);
        st(8'h60);
        wr(8'h04, 8'hC4);
        wb(8'hA5, 1'b1);
        st(8'h80);
        chk(8'h0C, 8'hA5, 8'hFF);
        wr(8'h04, 8'h84);
        wb(8'h3C, 1'b0);
        st(8'h88);
        wr(8'h04, 8'hC4);
        i_mst.stop();
        @(posedge mclk);
        sleep_active <= 1'b1;
        i_mst.start();
        wb(8'h00, 1'b1);
        st(8'h70);
        sleep_active <= 1'b0;
        wr(8'h04, 8'hC4);
        wb(8'h11, 1'b1);
        st(8'h90);
        wr(8'h04, 8'h84);
        wb(8'h22, 1'b0);
        st(8'h98);
        wr(8'h04, 8'hC4);
        i_mst.stop();
        n_tests++;
        if (n_wake != 1) mm("wake count");
        i_mst.start();
        wb(8'h54, 1'b1);
        st(8'h60);
        wr(8'h04, 8'hC4);
        i_mst.stop();
        st(8'hA0);
        wr(8'h04, 8'hE4);
        repeat (4) @(posedge mclk);
        n_tests++;
        if (bus_start_req !== 1'b1) mm("start request");
        wr(8'h04, 8'h44);
        txs(1'b0, 1'b1, 8'hC8);
        txs(1'b1, 1'b0, 8'hC0);
        wr(8'h04, 8'h04);
        i_mst.start();
        wb(8'h54, 1'b0);
        i_mst.stop();
        chk(8'h08, 8'hF8, 8'hF8);
        wr(8'h00, 8'h54);
        wr(8'h04, 8'h44);
        i_mst.start();
        wb(8'h00, 1'b0);
        i_mst.start();
        wb(8'h54, 1'b1);
        st(8'h60);
        wr(8'h04, 8'hC4);
        i_mst.stop();
        st(8'hA0);
        wr(8'h04, 8'hC4);
        results();
    end
    // Watchdog, about 20000 cycles
    initial begin
        #2000000;
        mm("timeout");
        results();
    end
endmodule
